// ==== logic/spt_top.sv ====
/*
 * Stepper phase translator top: pin synchronisers, step edge detection,
 * step pulse doubler, direction memory, chopper steering, output stage
 * and an APB slave with control, period, delay and status registers.
 * Assumes host pins are asynchronous to pclk and the current comparators
 * deliver a digital trip level on the sense inputs.
 */
`timescale 1ns/100ps
`default_nettype none
module spt_top #(
	parameter int unsigned GHOST_DEFAULT = spt_pkg::GHOST_CYCLES,
	parameter int unsigned CHOP_DEFAULT = spt_pkg::CHOP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [spt_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic step_n,
	input wire logic rotation_direction,
	input wire logic half_select,
	input wire logic chop_on_phases,
	input wire logic enable,
	input wire logic home_reset_n,
	input wire logic current_sense_ab,
	input wire logic current_sense_cd,
	output logic [3:0] phase_outputs,
	output logic inhibit_ab_n,
	output logic inhibit_cd_n,
	output logic home_o,
	output logic home_oe,
	output logic dir_mem_o,
	output logic dir_mem_oe,
	output logic chop_sync
);
	// period and delay registers are CNT_W wide
	if (GHOST_DEFAULT >= (1 << spt_pkg::CNT_W) || GHOST_DEFAULT == 0)
	begin : g_chk_ghost
		$error("GHOST_DEFAULT must fit the delay register and be nonzero");
	end
	if (CHOP_DEFAULT >= (1 << spt_pkg::CNT_W) || CHOP_DEFAULT < 2)
	begin : g_chk_chop
		$error("CHOP_DEFAULT must fit the period register and be at least 2");
	end

	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	logic s_step_n, s_dir, s_half, s_ctrl, s_en, s_rst_n, s_sab, s_scd;
	logic step_prev_reg;
	logic host_rise;
	logic ghost_fire;
	logic step_evt;
	logic step_up;
	logic dir_reg;
	logic doubler_reg;
	logic [spt_pkg::CNT_W-1:0] chop_period_reg;
	logic [spt_pkg::CNT_W-1:0] ghost_delay_reg;
	logic [spt_pkg::CNT_W-1:0] ghost_cnt_reg;
	spt_pkg::spt_ghost_t ghost_state_reg;
	logic [2:0] state_idx;
	logic [3:0] ph;
	logic chop_ab, chop_cd, osc_start;
	logic pair_ab, pair_cd;
	logic apb_setup, apb_write;
	logic addr_ok;
	logic [31:0] rd_next;

	// two flip-flops on every host and sense pin before any logic looks at it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= spt_pkg::SYNC_RESET;
			sync2_reg <= spt_pkg::SYNC_RESET;
		end
		else if (ce)
		begin
			sync1_reg <= {step_n, rotation_direction, half_select,
				chop_on_phases, enable, home_reset_n,
				current_sense_ab, current_sense_cd};
			sync2_reg <= sync1_reg;
		end
	end
	assign {s_step_n, s_dir, s_half, s_ctrl, s_en, s_rst_n, s_sab, s_scd} = sync2_reg;

	// step edge detector: the low pulse counts once, at its rising edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			step_prev_reg <= 1'b1;
		else if (ce)
			step_prev_reg <= s_step_n;
	end
	assign host_rise = s_step_n && !step_prev_reg;

	// direction flip-flop, loaded only at a host step so the ghost follows it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dir_reg <= 1'b0;
		else if (ce && host_rise)
			dir_reg <= s_dir;
	end

	// a ghost step uses the stored direction, a host step the live one
	assign step_up = host_rise ? s_dir : dir_reg;

	// doubler: a new host step restarts the delay, so the ghost never doubles up
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ghost_state_reg <= spt_pkg::SPT_G_IDLE;
			ghost_cnt_reg <= '0;
		end
		else if (ce)
		begin
			unique case (ghost_state_reg)
				spt_pkg::SPT_G_IDLE:
				begin
					if (host_rise && doubler_reg)
					begin
						ghost_state_reg <= spt_pkg::SPT_G_WAIT;
						ghost_cnt_reg <= ghost_delay_reg;
					end
				end
				spt_pkg::SPT_G_WAIT:
				begin
					if (host_rise)
						ghost_cnt_reg <= ghost_delay_reg;
					else if (ghost_cnt_reg == '0 || !doubler_reg)
						ghost_state_reg <= spt_pkg::SPT_G_IDLE;
					else
						ghost_cnt_reg <= ghost_cnt_reg - 1'b1;
				end
			endcase
		end
	end
	assign ghost_fire = (ghost_state_reg == spt_pkg::SPT_G_WAIT) && !host_rise
		&& doubler_reg && ghost_cnt_reg == '0;
	assign step_evt = host_rise || ghost_fire;

	spt_translator u_translator (
		.clk(pclk),
		.rst_n(presetn),
		.ce(ce),
		.step_evt(step_evt),
		.step_up(step_up),
		.half_mode(s_half),
		.home_req(!s_rst_n),
		.state_idx(state_idx)
	);

	spt_chopper u_chopper (
		.clk(pclk),
		.rst_n(presetn),
		.ce(ce),
		.period(chop_period_reg),
		.sense_ab(s_sab),
		.sense_cd(s_scd),
		.chop_ab(chop_ab),
		.chop_cd(chop_cd),
		.osc_start(osc_start)
	);

	// a pair with neither phase on is inhibited for fast decay
	assign ph = spt_pkg::phase_of(state_idx);
	assign pair_ab = ph[3] || ph[2];
	assign pair_cd = ph[1] || ph[0];

	// output stage; enable low overrides everything
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_outputs <= 4'h0;
			inhibit_ab_n <= 1'b0;
			inhibit_cd_n <= 1'b0;
		end
		else if (ce)
		begin
			if (!s_en)
			begin
				phase_outputs <= 4'h0;
				inhibit_ab_n <= 1'b0;
				inhibit_cd_n <= 1'b0;
			end
			else if (s_ctrl)
			begin
				phase_outputs <= ph & {chop_ab, chop_ab, chop_cd, chop_cd};
				inhibit_ab_n <= pair_ab;
				inhibit_cd_n <= pair_cd;
			end
			else
			begin
				phase_outputs <= ph;
				inhibit_ab_n <= pair_ab && chop_ab;
				inhibit_cd_n <= pair_cd && chop_cd;
			end
		end
	end

	// open-collector pins: the transistor releases home while at home
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			home_o <= 1'b0;
			home_oe <= 1'b0;
			dir_mem_o <= 1'b0;
			dir_mem_oe <= 1'b0;
			chop_sync <= 1'b0;
		end
		else if (ce)
		begin
			home_oe <= (state_idx != spt_pkg::HOME_IDX);
			dir_mem_oe <= doubler_reg && dir_reg;
			chop_sync <= osc_start;
		end
	end

	// apb: no wait states, the answer is built in the setup cycle
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pready && pwrite;
	assign addr_ok = paddr == spt_pkg::ADDR_CTRL || paddr == spt_pkg::ADDR_CHOP
		|| paddr == spt_pkg::ADDR_GHOST || paddr == spt_pkg::ADDR_STATUS;

	// read mux; unmapped reads return zero
	always_comb
	begin
		rd_next = 32'h0;
		unique case (paddr)
			spt_pkg::ADDR_CTRL: rd_next[spt_pkg::CTRL_DOUBLER_BIT] = doubler_reg;
			spt_pkg::ADDR_CHOP: rd_next[spt_pkg::CNT_W-1:0] = chop_period_reg;
			spt_pkg::ADDR_GHOST: rd_next[spt_pkg::CNT_W-1:0] = ghost_delay_reg;
			spt_pkg::ADDR_STATUS:
			begin
				rd_next[spt_pkg::ST_STATE_LSB +: 3] = state_idx;
				rd_next[spt_pkg::ST_HOME_BIT] = state_idx == spt_pkg::HOME_IDX;
				rd_next[spt_pkg::ST_DIR_BIT] = dir_reg;
				rd_next[spt_pkg::ST_PHASE_LSB +: 4] = phase_outputs;
				rd_next[spt_pkg::ST_INH_LSB +: 2] = {inhibit_ab_n, inhibit_cd_n};
			end
			default: rd_next = 32'h0;
		endcase
	end

	// handshake and read data; status sampled in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else if (ce)
		begin
			pready <= apb_setup;
			pslverr <= apb_setup && !addr_ok;
			if (apb_setup && !pwrite)
				prdata <= rd_next;
		end
	end

	// writable registers; writes to status or unmapped space are dropped
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			doubler_reg <= spt_pkg::CTRL_DOUBLER_RESET;
			chop_period_reg <= spt_pkg::CNT_W'(CHOP_DEFAULT - 1);
			ghost_delay_reg <= spt_pkg::CNT_W'(GHOST_DEFAULT);
		end
		else if (ce && apb_write)
		begin
			if (paddr == spt_pkg::ADDR_CTRL)
				doubler_reg <= pwdata[spt_pkg::CTRL_DOUBLER_BIT];
			if (paddr == spt_pkg::ADDR_CHOP)
				chop_period_reg <= pwdata[spt_pkg::CNT_W-1:0];
			if (paddr == spt_pkg::ADDR_GHOST)
				ghost_delay_reg <= pwdata[spt_pkg::CNT_W-1:0];
		end
	end

	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_step_moves: assert property ((ce && step_evt && s_rst_n)
		|=> state_idx != $past(state_idx))
		else $error("step did not move translator");
	a_half_one: assert property ((ce && step_evt && s_rst_n && s_half)
		|=> (3'(state_idx - $past(state_idx)) == 3'h1)
		|| (3'(state_idx - $past(state_idx)) == 3'h7))
		else $error("half step moved by other than one");
	a_full_parity: assert property ((ce && step_evt && s_rst_n && !s_half)
		|=> state_idx[0] == $past(state_idx[0]))
		else $error("full step changed state parity");
	a_no_step_hold: assert property ((ce && !step_evt && s_rst_n)
		|=> $stable(state_idx))
		else $error("translator moved without a step");
	a_dir_latched: assert property (!(ce && host_rise) |=> $stable(dir_reg))
		else $error("direction flip-flop changed between steps");
	a_reset_home: assert property ((ce && !s_rst_n)
		|=> state_idx == spt_pkg::HOME_IDX ##1 (!ce || home_oe == 1'b0))
		else $error("reset pin did not return home");
	a_home_out: assert property ((ce && state_idx == spt_pkg::HOME_IDX) |=> !home_oe)
		else $error("home not indicated");
	a_enable_off: assert property ((ce && !s_en)
		|=> phase_outputs == 4'h0 && !inhibit_ab_n && !inhibit_cd_n)
		else $error("outputs not forced low while disabled");
	a_inh_chop: assert property ((ce && s_en && !s_ctrl && !chop_ab)
		|=> !inhibit_ab_n && phase_outputs == $past(ph))
		else $error("inhibit chopping wrong");
	a_phase_chop: assert property ((ce && s_en && s_ctrl && !chop_cd)
		|=> phase_outputs[1:0] == 2'b00 && inhibit_cd_n == $past(pair_cd))
		else $error("phase chopping wrong");
	a_chop_cycle: assert property ((ce && osc_start) |=> chop_ab && chop_cd)
		else $error("oscillator cycle did not enable drive");
	// a ghost step must move the translator one way only, the way the last host step went
	a_ghost_dir: assert property ((ce && ghost_fire && s_rst_n && s_half)
		|=> 3'(state_idx - $past(state_idx)) == ($past(dir_reg) ? 3'h1 : 3'h7))
		else $error("ghost step ignored the stored direction");

	c_ghost: cover property (ce && ghost_fire);
	c_wave_full: cover property (ce && step_evt && !s_half && state_idx[0]);
	c_chop_trip: cover property (ce && chop_ab ##1 !chop_ab);
	c_apb_read: cover property (psel && penable && pready && !pwrite);
endmodule
`default_nettype wire

// ==== logic/spt_pkg.sv ====
/*
 * Shared constants for the stepper phase translator: timing, register map,
 * status field layout, home state and the half-step phase table.
 * Assumes a 20 MHz pclk and a 32-bit APB register bus.
 */
package spt_pkg;
	// clock and timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int CHOP_PERIOD_NS = 50000;
	localparam int CHOP_CYCLES = CHOP_PERIOD_NS / CLK_PERIOD_NS;
	localparam int GHOST_DELAY_NS = 500000;
	localparam int GHOST_CYCLES = GHOST_DELAY_NS / CLK_PERIOD_NS;

	// register map, byte addresses
	localparam int APB_AW = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CHOP = 8'h04;
	localparam logic [7:0] ADDR_GHOST = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;

	// control fields
	localparam int CTRL_DOUBLER_BIT = 0;
	localparam logic CTRL_DOUBLER_RESET = 1'b0;
	localparam int CNT_W = 16;

	// status fields
	localparam int ST_STATE_LSB = 0;
	localparam int ST_HOME_BIT = 3;
	localparam int ST_DIR_BIT = 4;
	localparam int ST_PHASE_LSB = 8;
	localparam int ST_INH_LSB = 12;

	// pin synchroniser order: step_n dir half ctrl en rst_n sab scd
	localparam logic [7:0] SYNC_RESET = 8'h84;

	// translator: index 0 is the home state, numbered state 1
	localparam logic [2:0] HOME_IDX = 3'h0;
	localparam logic [3:0] HOME_PHASES = 4'h5;

	typedef enum logic [0:0] {SPT_G_IDLE, SPT_G_WAIT} spt_ghost_t;

	// phase pattern A B C D for each index; even index is an odd state number
	function automatic logic [3:0] phase_of(input logic [2:0] idx);
		logic [3:0] p;
		p = HOME_PHASES;
		unique case (idx)
			3'h0: p = HOME_PHASES;
			3'h1: p = 4'h1;
			3'h2: p = 4'h9;
			3'h3: p = 4'h8;
			3'h4: p = 4'ha;
			3'h5: p = 4'h2;
			3'h6: p = 4'h6;
			3'h7: p = 4'h4;
		endcase
		return p;
	endfunction
endpackage

// ==== logic/spt_translator.sv ====
/*
 * Eight-state step translator. Moves one index per step in half mode, two
 * in full mode, so the parity chosen at the switch to full mode is kept.
 * Assumes step_evt is a one-cycle pulse on pclk and home_req a level.
 */
`timescale 1ns/100ps
`default_nettype none
module spt_translator (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic step_evt,
	input wire logic step_up,
	input wire logic half_mode,
	input wire logic home_req,
	output logic [2:0] state_idx
);
	logic [2:0] step_amt;

	// full mode skips alternate states, keeping wave or two-phase drive
	assign step_amt = half_mode ? 3'h1 : 3'h2;

	// home has priority so a held reset pin swallows steps
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			state_idx <= spt_pkg::HOME_IDX;
		else if (ce)
		begin
			if (home_req)
				state_idx <= spt_pkg::HOME_IDX;
			else if (step_evt && step_up)
				state_idx <= state_idx + step_amt;
			else if (step_evt)
				state_idx <= state_idx - step_amt;
		end
	end
endmodule
`default_nettype wire

// ==== logic/spt_chopper.sv ====
/*
 * Chopper oscillator and the two current flip-flops. Each oscillator cycle
 * turns both windings on; a tripped comparator turns its pair off.
 * Assumes sense inputs are already synchronised to clk.
 */
`timescale 1ns/100ps
`default_nettype none
module spt_chopper (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [spt_pkg::CNT_W-1:0] period,
	input wire logic sense_ab,
	input wire logic sense_cd,
	output logic chop_ab,
	output logic chop_cd,
	output logic osc_start
);
	logic [spt_pkg::CNT_W-1:0] cnt_reg;

	assign osc_start = (cnt_reg == '0);

	// count down; the period is reloaded each cycle so writes apply next
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_reg <= '0;
		else if (ce)
			cnt_reg <= osc_start ? period : cnt_reg - 1'b1;
	end

	// the oscillator start wins over a trip in the same cycle
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chop_ab <= 1'b0;
			chop_cd <= 1'b0;
		end
		else if (ce)
		begin
			if (osc_start)
			begin
				chop_ab <= 1'b1;
				chop_cd <= 1'b1;
			end
			else
			begin
				if (sense_ab)
					chop_ab <= 1'b0;
				if (sense_cd)
					chop_cd <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== dv/spt_host.sv ====
/*
 * Host model: drives the step, direction and step-size pins.
 * Assumes pclk runs free and the bench calls pulse() for each step.
 */
`timescale 1ns/100ps
`default_nettype none
module spt_host (
	input wire logic pclk,
	output logic step_n,
	output logic rotation_direction,
	output logic half_select
);
	// pins idle with step high, as a real host leaves them
	initial
	begin
		step_n = 1'b1;
		rotation_direction = 1'b1;
		half_select = 1'b1;
	end

	// one low-going pulse; direction and size move while the pin is low,
	// so the device must cope with changes at any moment
	task automatic pulse(input logic dir, input logic half, input int lo);
	begin
		@(posedge pclk);
		step_n <= 1'b0;
		@(posedge pclk);
		rotation_direction <= dir;
		half_select <= half;
		repeat (lo) @(posedge pclk);
		step_n <= 1'b1;
		repeat (5) @(posedge pclk);
	end
	endtask
endmodule
`default_nettype wire

// ==== dv/spt_top_tb.sv ====
/*
 * Self-checking bench for spt_top: reference index model, APB master,
 * host model on the step pins, chopper and doubler checks.
 * Assumes short parameter values so the run stays brief.
 */
`timescale 1ns/100ps
`default_nettype none
module spt_top_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, step_n, rotation_direction, half_select;
	logic chop_on_phases = 1'b0;
	logic enable = 1'b1;
	logic home_reset_n = 1'b1;
	logic sense_ab = 1'b0;
	logic sense_cd = 1'b0;
	logic [3:0] phase_outputs;
	logic inhibit_ab_n, inhibit_cd_n, home_o, home_oe, dir_mem_o, dir_mem_oe, chop_sync;
	int failures = 0;
	int samples_checked = 0;
	int idx = 0;
	int a, b, c;
	logic [31:0] rd;
	logic err;
	logic [3:0] tbl [8] = '{4'h5, 4'h1, 4'h9, 4'h8, 4'ha, 4'h2, 4'h6, 4'h4};

	// free-running 20 MHz clock
	always #25 pclk = ~pclk;

	spt_host i_host (.pclk(pclk), .step_n(step_n), .rotation_direction(rotation_direction),
		.half_select(half_select));

	spt_top #(.GHOST_DEFAULT(5), .CHOP_DEFAULT(8)) i_dut (.pclk(pclk), .presetn(presetn),
		.ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.step_n(step_n), .rotation_direction(rotation_direction),
		.half_select(half_select), .chop_on_phases(chop_on_phases), .enable(enable),
		.home_reset_n(home_reset_n), .current_sense_ab(sense_ab),
		.current_sense_cd(sense_cd), .phase_outputs(phase_outputs),
		.inhibit_ab_n(inhibit_ab_n), .inhibit_cd_n(inhibit_cd_n), .home_o(home_o),
		.home_oe(home_oe), .dir_mem_o(dir_mem_o), .dir_mem_oe(dir_mem_oe),
		.chop_sync(chop_sync));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
	begin
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
		end
	end
	endtask

	task automatic close_out();
	begin
		$display("checks %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask

	// one APB transfer; the request is held until pready is seen high
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		int k;
	begin
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 50)
		begin
			k++;
			@(posedge pclk);
		end
		if (k == 50)
			failures++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask

	// outputs expected with steady chopper, sense low and enable high
	task automatic chk_out();
		logic [3:0] p;
	begin
		p = tbl[idx];
		chk(phase_outputs, p);
		chk(inhibit_ab_n, p[3] | p[2]);
		chk(inhibit_cd_n, p[1] | p[0]);
		chk(home_oe, idx != 0);
	end
	endtask

	// phases must not move while the step pin is still low
	task automatic step(input logic dir, input logic half);
	begin
		fork
			i_host.pulse(dir, half, 3 + $urandom % 3);
			begin
				repeat (4) @(posedge pclk);
				chk(phase_outputs, tbl[idx]);
			end
		join
		idx = (idx + (dir ? 1 : 7) * (half ? 1 : 2)) % 8;
		chk_out();
		apb(1'b0, spt_pkg::ADDR_STATUS, 32'h0);
		chk(rd[2:0], idx);
	end
	endtask

	// watchdog: the sequence needs a few thousand cycles at most
	initial
	begin
		#(20000 * 50);
		failures++;
		close_out();
	end

	// main sequence
	initial
	begin
		a = $urandom(44582);
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
		chk_out();
		apb(1'b0, spt_pkg::ADDR_CHOP, 32'h0);
		chk(rd, 32'h7);
		apb(1'b0, spt_pkg::ADDR_GHOST, 32'h0);
		chk(rd, 32'h5);
		apb(1'b0, spt_pkg::ADDR_STATUS, 32'h0);
		chk(rd, 32'h3508);
		apb(1'b1, 8'h10, 32'h1);
		chk(err, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 12; i++)
			step($urandom % 2, 1'b1);
		// full mode from an even, then an odd state number
		for (int s = 0; s < 2; s++)
		begin
			if (idx % 2 == s)
				step(1'b1, 1'b1);
			repeat (4)
			begin
				step($urandom % 2, 1'b0);
				chk($countones(phase_outputs), 2 - idx % 2);
			end
		end
		enable <= 1'b0;
		repeat (6) @(posedge pclk);
		chk({phase_outputs, inhibit_ab_n, inhibit_cd_n}, 6'h0);
		enable <= 1'b1;
		home_reset_n <= 1'b0;
		repeat (4) @(posedge pclk);
		home_reset_n <= 1'b1;
		repeat (6) @(posedge pclk);
		idx = 0;
		chk_out();
		// oscillator period is the register value plus one
		apb(1'b1, spt_pkg::ADDR_CHOP, 32'h9);
		repeat (20) @(posedge pclk);
		a = 0;
		repeat (100)
		begin
			@(posedge pclk);
			a += chop_sync;
		end
		chk(a, 10);
		sense_ab <= 1'b1;
		for (int m = 0; m < 2; m++)
		begin
			chop_on_phases <= m[0];
			repeat (6) @(posedge pclk);
			a = 0;
			b = 0;
			c = 0;
			repeat (40)
			begin
				@(posedge pclk);
				a += (inhibit_ab_n !== 1'b1);
				b += (phase_outputs[3:2] !== 2'b01);
				c += ({phase_outputs[1:0], inhibit_cd_n} !== 3'b011);
			end
			chk(m ? a : b, 0);
			chk((m ? b : a) > 0, 1);
			chk(c, 0);
		end
		sense_ab <= 1'b0;
		chop_on_phases <= 1'b0;
		// doubler: a ghost step follows each host step in its direction
		apb(1'b1, spt_pkg::ADDR_GHOST, 32'd20);
		apb(1'b1, spt_pkg::ADDR_CTRL, 32'h1);
		for (int d = 1; d >= 0; d--)
		begin
			step(d[0], 1'b1);
			repeat (30) @(posedge pclk);
			idx = (idx + (d ? 1 : 7)) % 8;
			chk_out();
			chk(dir_mem_oe, d[0]);
		end
		apb(1'b1, spt_pkg::ADDR_CTRL, 32'h0);
		repeat (4) @(posedge pclk);
		chk({dir_mem_oe, dir_mem_o, home_o}, 3'h0);
		close_out();
	end
endmodule
`default_nettype wire
